// [radio_ctrl_regs.sv]
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module radio_ctrl_regs
(
	input  wire logic                                 core_clk,
	input  wire logic                                 rst,
	input  wire logic [7:0]                           regAddr,
	input  wire logic [7:0]                           regWdata,
	input  wire logic                                 regWrite,
	input  wire logic                                 regRead,
	output logic      [7:0]                           regRdata,
	input  wire logic [radio_ctrl_pkg::PIN_COUNT-1:0] pinIn,
	output logic      [radio_ctrl_pkg::PIN_COUNT-1:0] pinOut,
	output logic      [radio_ctrl_pkg::PIN_COUNT-1:0] pinOe,
	output logic                                      sleepRequest,
	output logic      [8:0]                           oscStartupCount,
	output logic                                      rfFsmReset,
	output logic                                      forceTxState,
	output logic                                      forceRxState,
	output logic                                      decryptStart,
	output logic                                      encryptStart,
	input  wire logic                                 decryptDone,
	input  wire logic                                 encryptDone,
	output logic                                      decryptBusy,
	output logic                                      encryptBusy,
	output radio_ctrl_pkg::suites_t                   suiteSelect
);
	localparam int PW = radio_ctrl_pkg::PIN_COUNT;

	radio_ctrl_pkg::bus_req_t  req;
	radio_ctrl_pkg::rf_mode_t  rfMode_reg;
	radio_ctrl_pkg::suites_t   suites_reg;
	logic [PW-1:0]             pinSync;
	logic [PW-1:0]             pinValue_reg;
	logic [PW-1:0]             pinDir_reg;
	logic [8:0]                wakeCount_reg;
	logic                      decBusy_reg;
	logic                      encBusy_reg;
	logic [7:0]                readMux;
	logic                      wrPinValue;
	logic                      wrPinDir;
	logic                      wrSleep;
	logic                      wrRfMode;
	logic                      wrSecurity;
	logic [PW-1:0]             pinReadback;
	logic                      hitPinValue;
	logic                      hitPinDir;
	logic                      hitSleep;
	logic                      hitRfMode;
	logic                      hitSecurity;
	logic [7:0]                rdPinValue;
	logic [7:0]                rdPinDir;
	logic [7:0]                rdSleep;
	logic [7:0]                rdRfMode;
	logic [7:0]                rdSecurity;
	logic                      decStartHit;
	logic                      encStartHit;
	radio_ctrl_pkg::suites_t   suites_next;

	assign req = '{addr: regAddr, wdata: regWdata, wr: regWrite, rd: regRead};

	pin_sync u_pin_sync
	(
		.core_clk (core_clk),
		.rst      (rst),
		.pinAsync (pinIn),
		.pinSync  (pinSync)
	);

	// one address decode shared by the write strobes and the read mux
	assign hitPinValue = (req.addr == radio_ctrl_pkg::ADDR_PIN_VALUE);
	assign hitPinDir   = (req.addr == radio_ctrl_pkg::ADDR_PIN_DIR);
	assign hitSleep    = (req.addr == radio_ctrl_pkg::ADDR_SLEEP_WAKE);
	assign hitRfMode   = (req.addr == radio_ctrl_pkg::ADDR_RF_MODE);
	assign hitSecurity = (req.addr == radio_ctrl_pkg::ADDR_SECURITY);

	assign wrPinValue = req.wr && hitPinValue;
	assign wrPinDir   = req.wr && hitPinDir;
	assign wrSleep    = req.wr && hitSleep;
	assign wrRfMode   = req.wr && hitRfMode;
	assign wrSecurity = req.wr && hitSecurity;

	// per pin: outputs read back their latch, inputs the synchronised level
	genvar gi;
	generate
		for (gi = 0; gi < PW; gi++)
		begin : g_pin
			assign pinReadback[gi] = pinDir_reg[gi] ? pinValue_reg[gi] : pinSync[gi];
		end
	endgenerate

	assign rdPinValue = {2'h0, pinReadback};
	assign rdPinDir   = {2'h0, pinDir_reg};
	// sleep request reads zero: it never stays set
	assign rdSleep    = {1'b0, wakeCount_reg[6:0]};
	assign rdRfMode   = {3'h0, wakeCount_reg[8:7], rfMode_reg};
	assign rdSecurity = {decBusy_reg, encBusy_reg, suites_reg};

	// unmapped addresses read as zero
	assign readMux = hitPinValue ? rdPinValue :
		hitPinDir ? rdPinDir :
		hitSleep ? rdSleep :
		hitRfMode ? rdRfMode :
		hitSecurity ? rdSecurity :
		8'h00;

	always_ff @(posedge core_clk)
	begin
		if (rst)
			regRdata <= 8'h00;
		else if (req.rd)
			regRdata <= readMux;
		else
			regRdata <= 8'h00;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			pinValue_reg <= '0;
			pinDir_reg   <= '0;
		end
		else
		begin
			if (wrPinValue)
				pinValue_reg <= req.wdata[PW-1:0];
			if (wrPinDir)
				pinDir_reg <= req.wdata[PW-1:0];
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			pinOut <= '0;
			pinOe  <= '0;
		end
		else
		begin
			pinOut <= wrPinValue ? req.wdata[PW-1:0] : pinValue_reg;
			pinOe  <= wrPinDir ? req.wdata[PW-1:0] : pinDir_reg;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			wakeCount_reg <= radio_ctrl_pkg::WAKE_COUNT_RESET;
		else
		begin
			if (wrSleep)
				wakeCount_reg[6:0] <= req.wdata[6:0];
			if (wrRfMode)
				wakeCount_reg[8:7] <= req.wdata[radio_ctrl_pkg::RF_WAKE_HI_LSB +: 2];
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			rfMode_reg <= '0;
		else if (wrRfMode)
		begin
			rfMode_reg.rfFsmReset   <= req.wdata[radio_ctrl_pkg::RF_RESET_BIT];
			rfMode_reg.forceTxState <= req.wdata[radio_ctrl_pkg::RF_TX_BIT];
			rfMode_reg.forceRxState <= req.wdata[radio_ctrl_pkg::RF_RX_BIT];
		end
	end

	assign decStartHit = wrSecurity && req.wdata[radio_ctrl_pkg::SEC_DEC_BIT];
	assign encStartHit = wrSecurity && req.wdata[radio_ctrl_pkg::SEC_ENC_BIT];

	// busy flags: a new start in the done cycle wins, so no start is lost
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			decBusy_reg <= 1'b0;
			encBusy_reg <= 1'b0;
		end
		else
		begin
			if (decStartHit)
				decBusy_reg <= 1'b1;
			else if (decryptDone)
				decBusy_reg <= 1'b0;
			if (encStartHit)
				encBusy_reg <= 1'b1;
			else if (encryptDone)
				encBusy_reg <= 1'b0;
		end
	end

	assign suites_next = {
		radio_ctrl_pkg::suite_t'(req.wdata[radio_ctrl_pkg::SLOT2_LSB +: 3]),
		radio_ctrl_pkg::suite_t'(req.wdata[radio_ctrl_pkg::SLOT1_LSB +: 3])
	};

	always_ff @(posedge core_clk)
	begin
		if (rst)
			suites_reg <= '0;
		else if (wrSecurity)
			suites_reg <= suites_next;
	end

	// one-cycle pulses, so the stored bits are clear again at once
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			sleepRequest <= 1'b0;
			decryptStart <= 1'b0;
			encryptStart <= 1'b0;
		end
		else
		begin
			sleepRequest <= wrSleep && req.wdata[radio_ctrl_pkg::SLEEP_REQ_BIT];
			decryptStart <= decStartHit;
			encryptStart <= encStartHit;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			oscStartupCount <= radio_ctrl_pkg::WAKE_COUNT_RESET;
			rfFsmReset      <= 1'b0;
			forceTxState    <= 1'b0;
			forceRxState    <= 1'b0;
		end
		else
		begin
			oscStartupCount <= wakeCount_reg;
			rfFsmReset      <= rfMode_reg.rfFsmReset;
			forceTxState    <= rfMode_reg.forceTxState;
			forceRxState    <= rfMode_reg.forceRxState;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			decryptBusy <= 1'b0;
			encryptBusy <= 1'b0;
			suiteSelect <= '0;
		end
		else
		begin
			decryptBusy <= decBusy_reg;
			encryptBusy <= encBusy_reg;
			suiteSelect <= suites_reg;
		end
	end
endmodule // radio_ctrl_regs

// [radio_ctrl_pkg.sv]
package radio_ctrl_pkg;

	localparam logic [7:0] ADDR_PIN_VALUE   = 8'h33;
	localparam logic [7:0] ADDR_PIN_DIR     = 8'h34;
	localparam logic [7:0] ADDR_SLEEP_WAKE  = 8'h35;
	localparam logic [7:0] ADDR_RF_MODE     = 8'h36;
	localparam logic [7:0] ADDR_SECURITY    = 8'h37;

	localparam int PIN_COUNT = 6;

	// field positions
	localparam int SLEEP_REQ_BIT  = 7;
	localparam int RF_WAKE_HI_LSB = 3;
	localparam int RF_RESET_BIT   = 2;
	localparam int RF_TX_BIT      = 1;
	localparam int RF_RX_BIT      = 0;
	localparam int SEC_DEC_BIT    = 7;
	localparam int SEC_ENC_BIT    = 6;
	localparam int SLOT2_LSB      = 3;
	localparam int SLOT1_LSB      = 0;

	localparam logic [8:0] WAKE_COUNT_RESET = 9'h000;
	localparam logic [8:0] WAKE_COUNT_ADVISED = 9'h05F;

	typedef enum logic [2:0] {
		SUITE_NONE        = 3'h0,
		SUITE_CTR         = 3'h1,
		SUITE_CCM_128     = 3'h2,
		SUITE_CCM_64      = 3'h3,
		SUITE_CCM_32      = 3'h4,
		SUITE_CBC_MAC_128 = 3'h5,
		SUITE_CBC_MAC_64  = 3'h6,
		SUITE_CBC_MAC_32  = 3'h7
	} suite_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_t;

	typedef struct packed {
		logic       rfFsmReset;
		logic       forceTxState;
		logic       forceRxState;
	} rf_mode_t;

	typedef struct packed {
		suite_t     slot2;
		suite_t     slot1;
	} suites_t;

endpackage

// [pin_sync.sv]
`timescale 1ns/1ps
module pin_sync
(
	input  wire logic                                 core_clk,
	input  wire logic                                 rst,
	input  wire logic [radio_ctrl_pkg::PIN_COUNT-1:0] pinAsync,
	output logic      [radio_ctrl_pkg::PIN_COUNT-1:0] pinSync
);
	logic [radio_ctrl_pkg::PIN_COUNT-1:0] stage1_reg;

	// first stage feeds only the second
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			stage1_reg <= '0;
			pinSync    <= '0;
		end
		else
		begin
			stage1_reg <= pinAsync;
			pinSync    <= stage1_reg;
		end
	end
endmodule // pin_sync

// [radio_ctrl_regs_props.sv]
`timescale 1ns/1ps
module radio_ctrl_regs_props
(
	input wire logic			core_clk,
	input wire logic			rst,
	input wire logic [7:0]		regAddr,
	input wire logic [7:0]		regWdata,
	input wire logic			regWrite,
	input wire logic [5:0]		pinOut,
	input wire logic [5:0]		pinOe,
	input wire logic			sleepRequest,
	input wire logic [8:0]		oscStartupCount,
	input wire logic			rfFsmReset,
	input wire logic			forceTxState,
	input wire logic			forceRxState,
	input wire logic			decryptStart,
	input wire logic			encryptStart,
	input radio_ctrl_pkg::suites_t	suiteSelect
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence wr_s(logic [7:0] a);
		regWrite && regAddr == a;
	endsequence

	sleep_pulse_a: assert property (wr_s(8'h35) ##0 regWdata[7] |=> sleepRequest)
		else $error("sleep pulse wrong");
	sleep_clear_a: assert property (sleepRequest |->
		$past(regWrite && regAddr == 8'h35 && regWdata[7]))
		else $error("sleep request not cleared");
	pin_dir_a: assert property (wr_s(8'h34) |=> pinOe == $past(regWdata[5:0]))
		else $error("pin enable wrong");
	pin_drive_a: assert property (wr_s(8'h33) |=> pinOut == $past(regWdata[5:0]))
		else $error("pin drive wrong");
	wake_high_a: assert property (wr_s(8'h36) |-> ##2 oscStartupCount[8:7] == $past(regWdata[4:3], 2))
		else $error("wake count high bits wrong");
	rf_mode_a: assert property (wr_s(8'h36) |-> ##2 {rfFsmReset, forceTxState, forceRxState} == $past(regWdata[2:0], 2))
		else $error("rf mode outputs wrong");
	dec_start_a: assert property (decryptStart == $past(regWrite && regAddr == 8'h37 && regWdata[7]))
		else $error("decrypt start wrong");
	enc_start_a: assert property (encryptStart == $past(regWrite && regAddr == 8'h37 && regWdata[6]))
		else $error("encrypt start wrong");
	suite_sel_a: assert property (wr_s(8'h37) |-> ##2 suiteSelect == $past(regWdata[5:0], 2))
		else $error("suite select wrong");
endmodule // radio_ctrl_regs_props

bind radio_ctrl_regs radio_ctrl_regs_props props
(
	.core_clk        (core_clk),
	.rst             (rst),
	.regAddr         (regAddr),
	.regWdata        (regWdata),
	.regWrite        (regWrite),
	.pinOut          (pinOut),
	.pinOe           (pinOe),
	.sleepRequest    (sleepRequest),
	.oscStartupCount (oscStartupCount),
	.rfFsmReset      (rfFsmReset),
	.forceTxState    (forceTxState),
	.forceRxState    (forceRxState),
	.decryptStart    (decryptStart),
	.encryptStart    (encryptStart),
	.suiteSelect     (suiteSelect)
);

// [radio_ctrl_regs_tb.sv]
`timescale 1ns/1ps
module radio_ctrl_regs_tb;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
	logic				core_clk, rst, regWrite, regRead, decryptDone, encryptDone;
	logic [7:0]			regAddr, regWdata, regRdata;
	logic [5:0]			pinIn, pinOut, pinOe;
	logic [8:0]			oscStartupCount;
	logic				sleepRequest, rfFsmReset, forceTxState, forceRxState;
	logic				decryptStart, encryptStart, decryptBusy, encryptBusy;
	radio_ctrl_pkg::suites_t	suiteSelect;
	int					error_cnt, n_checks;
	row_t				rows [8] = '{
		'{8'h34, 8'hFF, 8'h3F},
		'{8'h33, 8'hEA, 8'h2A},
		'{8'h35, 8'hDF, 8'h5F},
		'{8'h36, 8'hFF, 8'h1F},
		'{8'h36, 8'h06, 8'h06},
		'{8'h36, 8'h02, 8'h02},
		'{8'h37, 8'h3F, 8'h3F},
		'{8'h38, 8'hFF, 8'h00}};

	radio_ctrl_regs uut
	(
		.core_clk        (core_clk),
		.rst             (rst),
		.regAddr         (regAddr),
		.regWdata        (regWdata),
		.regWrite        (regWrite),
		.regRead         (regRead),
		.regRdata        (regRdata),
		.pinIn           (pinIn),
		.pinOut          (pinOut),
		.pinOe           (pinOe),
		.sleepRequest    (sleepRequest),
		.oscStartupCount (oscStartupCount),
		.rfFsmReset      (rfFsmReset),
		.forceTxState    (forceTxState),
		.forceRxState    (forceRxState),
		.decryptStart    (decryptStart),
		.encryptStart    (encryptStart),
		.decryptDone     (decryptDone),
		.encryptDone     (encryptDone),
		.decryptBusy     (decryptBusy),
		.encryptBusy     (encryptBusy),
		.suiteSelect     (suiteSelect)
	);

	task chk(input string w, input logic [8:0] e, input logic [8:0] g);
		n_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", w, e, g);
		end
	endtask

	// caller may start another write in the step this one ends: its regWrite set comes later and wins
	task wr(input logic [7:0] a, input logic [7:0] d);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'h1;
		@(posedge core_clk);
		regWrite <= 1'h0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e);
		regAddr <= a;
		regRead <= 1'h1;
		@(posedge core_clk);
		regRead <= 1'h0;
		@(negedge core_clk);
		chk("read data", {1'h0, e}, {1'h0, regRdata});
		@(posedge core_clk);
	endtask

	task close_out;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		core_clk = 1'h0;
		forever #25 core_clk = ~core_clk;
	end

	initial
	begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		close_out();
	end

	initial
	begin
		{rst, regWrite, regRead, decryptDone, encryptDone} = 5'h10;
		{regAddr, regWdata, pinIn} = 22'h0;
		repeat (10) @(posedge core_clk);
		rst <= 1'h0;
		@(posedge core_clk);
		for (int i = 0; i < 5; i++)
			rd(8'(8'h33 + i), 8'h00);
		chk("pin enable", 9'h000, {3'h0, pinOe});
		$display("reset test done");
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
		end
		chk("rf mode", 9'h002, {6'h0, rfFsmReset, forceTxState, forceRxState});
		chk("wake count", radio_ctrl_pkg::WAKE_COUNT_ADVISED, oscStartupCount);
		$display("row test done");
		wr(8'h35, 8'hDF);
		@(negedge core_clk);
		chk("sleep request", 9'h001, {8'h00, sleepRequest});
		@(posedge core_clk);
		@(negedge core_clk);
		chk("sleep request", 9'h000, {8'h00, sleepRequest});
		@(posedge core_clk);
		rd(8'h35, 8'h5F);
		$display("sleep test done");
		for (int k = 0; k < 8; k++)
		begin
			wr(8'h37, {2'h0, 3'(k), ~3'(k)});
			@(posedge core_clk);
			@(negedge core_clk);
			chk("suite", {3'h0, 3'(k), ~3'(k)}, {3'h0, suiteSelect});
			@(posedge core_clk);
		end
		$display("suite test done");
		for (int b = 0; b < 2; b++)
		begin
			wr(8'h37, b ? 8'h40 : 8'h80);
			rd(8'h37, b ? 8'h40 : 8'h80);
			@(negedge core_clk);
			chk("busy", 9'h001, {8'h00, b ? encryptBusy : decryptBusy});
			@(posedge core_clk);
			{decryptDone, encryptDone} <= b ? 2'h1 : 2'h2;
			@(posedge core_clk);
			{decryptDone, encryptDone} <= 2'h0;
			rd(8'h37, 8'h00);
		end
		$display("crypto test done");
		wr(8'h34, 8'h05);
		rd(8'h34, 8'h05);
		wr(8'h33, 8'h12);
		// input bits differ from the latch on output bits, so a wrong select shows
		pinIn <= 6'h3F;
		// two sync flops before the level is readable
		repeat (3) @(posedge core_clk);
		rd(8'h33, 8'h3A);
		chk("pin out", 9'h012, {3'h0, pinOut});
		chk("pin enable", 9'h005, {3'h0, pinOe});
		$display("pin test done");
		wr(8'h36, 8'h04);
		@(posedge core_clk);
		@(negedge core_clk);
		chk("rf reset", 9'h001, {8'h00, rfFsmReset});
		@(posedge core_clk);
		wr(8'h36, 8'h00);
		// 192 us of 50 ns cycles for calibration
		repeat (3840) @(posedge core_clk);
		@(negedge core_clk);
		chk("rf reset", 9'h000, {8'h00, rfFsmReset});
		@(posedge core_clk);
		$display("rf reset test done");
		rst <= 1'h1;
		repeat (2) @(posedge core_clk);
		rst <= 1'h0;
		@(negedge core_clk);
		chk("pin out", 9'h000, {3'h0, pinOut});
		chk("pin enable", 9'h000, {3'h0, pinOe});
		chk("wake count", radio_ctrl_pkg::WAKE_COUNT_RESET, oscStartupCount);
		@(posedge core_clk);
		rd(8'h35, 8'h00);
		rd(8'h34, 8'h00);
		$display("mid reset test done");
		close_out();
	end
endmodule // radio_ctrl_regs_tb
